/* File: rtl/smtrp_pkg.sv */
// package: command codes, slave address table and timing for the temperature port
package smtrp_pkg;
  // command codes of the byte registers
  localparam logic [7:0] CMD_CH1    = 8'h00;
  localparam logic [7:0] CMD_CH2    = 8'h01;
  localparam logic [7:0] CMD_OFFS   = 8'h17;
  localparam logic [7:0] CMD_CFG    = 8'h20;
  localparam logic [7:0] CMD_FRAC   = 8'h21;
  localparam logic [7:0] CFG_RST    = 8'h00;
  localparam logic [7:0] OFFS_RST   = 8'h00;
  localparam logic [7:0] TEMP_RST   = 8'h00;
  localparam logic [7:0] TEMP_MAX   = 8'hff;
  localparam int         CFG_TWO_TH = 0;
  localparam int         FRAC_BITS  = 3;
  localparam int         ADC_W      = 12;
  // smbus alert response address
  localparam logic [6:0] ARA_ADDR   = 7'h0c;
  // strap level codes from the three-level pad detectors
  localparam logic [1:0] LVL_HIGH   = 2'h2;
  localparam logic [1:0] LVL_BAD    = 2'h3;
  // nine selectable addresses, index = 3*strap_a + strap_b; values are arbitrary
  localparam logic [8:0][6:0] ADDR_TBL = {7'h4e, 7'h4d, 7'h4c, 7'h2b, 7'h2a,
                                          7'h29, 7'h1a, 7'h19, 7'h18};
  // integration time per channel
  localparam int unsigned CONV_MS   = 120;
  localparam int unsigned CLK_KHZ   = 100_000;
  localparam int unsigned CONV_CYC  = CONV_MS * CLK_KHZ;
  typedef enum logic [8:0] {
    ST_IDLE  = 9'h001,
    ST_ADDR  = 9'h002,
    ST_ACK_A = 9'h004,
    ST_CMD   = 9'h008,
    ST_ACK_C = 9'h010,
    ST_WDATA = 9'h020,
    ST_ACK_D = 9'h040,
    ST_RDATA = 9'h080,
    ST_RACK  = 9'h100
  } smtrp_st_t;
  typedef enum logic [3:0] {
    SQ_LOW  = 4'h1,
    SQ_HIGH = 4'h2,
    SQ_TH1  = 4'h4,
    SQ_TH2  = 4'h8
  } smtrp_sq_t;
endpackage

/* File: rtl/smtrp_top.sv */
// smbus slave register port with the two-channel temperature result registers
//
// Operation
// - slave handles write byte, read byte, send byte and receive byte only
// - all visible state is byte registers chosen by the command byte
// - nine different slave addresses selectable
// - slave address comes from the two address strap inputs
// - read byte: addr+w, command, repeated start, addr+r, data, master nack, stop
// - send byte stores the command byte as the selected register
// - receive byte returns the register chosen by the last command byte
// - receive byte format returns own address on alert response query
// - channel results readable at commands 00h and 01h
// - result is unsigned, bit 0 one degree, bit 7 128 degrees
// - data bytes leave most significant bit first
// - results below zero read as 00h
// - below-zero thermistor result clamps to zero with negative offset programmed
// - local channel fraction register holds three bits, 0.5 to 0.125 degree
// - each channel integrates for about 120 ms
// - both channels convert in turn, even if one is unused
// - channels are die sensor plus thermistor, or two thermistors
// - die channel measures at low then high bias current
// - thermistor byte is resistor voltage fraction, lsb about 7.68 mV
`timescale 1ns/1ps
`default_nettype none
module smtrp_top
  import smtrp_pkg::*;
#(
  parameter int unsigned CONV_CYC_P = CONV_CYC
) (
  input  wire logic                    clk_i,
  input  wire logic                    rstn_i,
  input  wire logic                    scl_i,
  input  wire logic                    sda_i,
  output logic                         sda_o,
  output logic                         sda_oe_o,
  input  wire logic [1:0]              slave_addr_strap_a_i,
  input  wire logic [1:0]              slave_addr_strap_b_i,
  input  wire logic                    alert_pend_i,
  input  wire logic signed [ADC_W-1:0] adc_result_i,
  output logic                         adc_chan_o,
  output logic                         bias_high_o,
  output logic                         two_th_o
);
  localparam int CW = $clog2(CONV_CYC_P + 1);
  localparam logic [CW-1:0] LEN_FULL = CW'(CONV_CYC_P);
  localparam logic [CW-1:0] LEN_HALF = CW'(CONV_CYC_P / 2);

  ////////////////////////////////////////////////////////////////////////////
  // pin synchronisers; first stages feed only the second stages
  logic            scl_s1_reg, scl_s2_reg, scl_d_reg;
  logic            sda_s1_reg, sda_s2_reg, sda_d_reg;
  logic [1:0]      sa_s1_reg, sa_s2_reg, sb_s1_reg, sb_s2_reg;
  logic [1:0]      strap_cnt_reg;
  logic [6:0]      own_addr_reg;
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      {scl_s1_reg, scl_s2_reg, scl_d_reg} <= 3'h7;
      {sda_s1_reg, sda_s2_reg, sda_d_reg} <= 3'h7;
      {sa_s1_reg, sa_s2_reg, sb_s1_reg, sb_s2_reg} <= 8'h00;
    end else begin
      {scl_s1_reg, scl_s2_reg, scl_d_reg} <= {scl_i, scl_s1_reg, scl_s2_reg};
      {sda_s1_reg, sda_s2_reg, sda_d_reg} <= {sda_i, sda_s1_reg, sda_s2_reg};
      {sa_s1_reg, sa_s2_reg} <= {slave_addr_strap_a_i, sa_s1_reg};
      {sb_s1_reg, sb_s2_reg} <= {slave_addr_strap_b_i, sb_s1_reg};
    end
  end

  // straps are caught once, shortly after reset release, then frozen
  wire logic [1:0] lvl_a    = (sa_s2_reg == LVL_BAD) ? LVL_HIGH : sa_s2_reg;
  wire logic [1:0] lvl_b    = (sb_s2_reg == LVL_BAD) ? LVL_HIGH : sb_s2_reg;
  wire logic [3:0] strap_ix = 4'(4'(lvl_a) * 4'd3 + 4'(lvl_b));
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      strap_cnt_reg <= 2'h0;
      own_addr_reg  <= 7'h00;
    end else if (strap_cnt_reg != 2'h3) begin
      strap_cnt_reg <= strap_cnt_reg + 2'h1;
      if (strap_cnt_reg == 2'h2) own_addr_reg <= ADDR_TBL[strap_ix];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // bus events
  wire logic scl_rise  = scl_s2_reg & ~scl_d_reg;
  wire logic scl_fall  = ~scl_s2_reg & scl_d_reg;
  wire logic bus_start = scl_s2_reg & scl_d_reg & sda_d_reg & ~sda_s2_reg;
  wire logic bus_stop  = scl_s2_reg & scl_d_reg & ~sda_d_reg & sda_s2_reg;

  smtrp_st_t   st_reg;
  logic [2:0]  cnt_reg;
  logic        full_reg, rw_reg, ara_reg, sda_oe_reg;
  logic [7:0]  rx_reg, tx_reg, cmd_reg, cfg_reg, offs_reg;
  logic [7:0]  ch1_reg, ch2_reg;
  logic [FRAC_BITS-1:0] frac_reg;

  wire logic rx_phase = (st_reg == ST_ADDR) | (st_reg == ST_CMD) | (st_reg == ST_WDATA);
  wire logic addr_hit = (rx_reg[7:1] == own_addr_reg);
  // alert query is answered only while an alert is pending, read direction only
  wire logic ara_hit  = (rx_reg[7:1] == ARA_ADDR) & rx_reg[0] & alert_pend_i;
  wire logic wr_en    = scl_fall & (st_reg == ST_WDATA) & full_reg;

  // register read selection; unmapped commands read zero
  wire logic [7:0] rd_data =
      (cmd_reg == CMD_CH1)  ? ch1_reg :
      (cmd_reg == CMD_CH2)  ? ch2_reg :
      (cmd_reg == CMD_FRAC) ? {frac_reg, {(8-FRAC_BITS){1'b0}}} :
      (cmd_reg == CMD_OFFS) ? offs_reg :
      (cmd_reg == CMD_CFG)  ? cfg_reg : 8'h00;
  wire logic [7:0] tx_load = ara_reg ? {own_addr_reg, 1'b0} : rd_data;

  ////////////////////////////////////////////////////////////////////////////
  // slave protocol: sample on scl rise, change sda after scl fall
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      st_reg     <= ST_IDLE;
      cnt_reg    <= 3'h0;
      full_reg   <= 1'b0;
      rw_reg     <= 1'b0;
      ara_reg    <= 1'b0;
      sda_oe_reg <= 1'b0;
      rx_reg     <= 8'h00;
      tx_reg     <= 8'h00;
      cmd_reg    <= 8'h00;
    end else if (bus_start) begin // repeated start too
      st_reg     <= ST_ADDR;
      cnt_reg    <= 3'h0;
      full_reg   <= 1'b0;
      sda_oe_reg <= 1'b0;
    end else if (bus_stop) begin
      st_reg     <= ST_IDLE;
      sda_oe_reg <= 1'b0;
    end else if (scl_rise && rx_phase) begin
      rx_reg   <= {rx_reg[6:0], sda_s2_reg};
      cnt_reg  <= cnt_reg + 3'h1;
      full_reg <= (cnt_reg == 3'h7);
    end else if (scl_rise && st_reg == ST_RDATA) begin
      cnt_reg  <= cnt_reg + 3'h1;
      full_reg <= (cnt_reg == 3'h7);
    end else if (scl_rise && st_reg == ST_RACK) begin
      st_reg <= ST_IDLE; // one byte per read, master nack expected
    end else if (scl_fall) begin
      case (st_reg)
        ST_ADDR: if (full_reg) begin
          full_reg <= 1'b0;
          if (addr_hit || ara_hit) begin
            sda_oe_reg <= 1'b1;
            rw_reg     <= rx_reg[0];
            ara_reg    <= ara_hit & ~addr_hit;
            st_reg     <= ST_ACK_A;
          end else begin
            st_reg <= ST_IDLE;
          end
        end
        ST_ACK_A: begin
          cnt_reg <= 3'h0;
          if (rw_reg) begin // read byte tail and receive byte
            tx_reg     <= tx_load;
            sda_oe_reg <= ~tx_load[7];
            st_reg     <= ST_RDATA;
          end else begin
            sda_oe_reg <= 1'b0;
            st_reg     <= ST_CMD;
          end
        end
        ST_CMD: if (full_reg) begin
          full_reg   <= 1'b0;
          cmd_reg    <= rx_reg; // kept as selection
          sda_oe_reg <= 1'b1;
          st_reg     <= ST_ACK_C;
        end
        ST_ACK_C: begin
          cnt_reg    <= 3'h0;
          sda_oe_reg <= 1'b0;
          st_reg     <= ST_WDATA;
        end
        ST_WDATA: if (full_reg) begin
          full_reg   <= 1'b0;
          sda_oe_reg <= 1'b1;
          st_reg     <= ST_ACK_D;
        end
        ST_ACK_D: begin
          sda_oe_reg <= 1'b0;
          st_reg     <= ST_IDLE; // further bytes are not acknowledged
        end
        ST_RDATA: if (full_reg) begin
          full_reg   <= 1'b0;
          sda_oe_reg <= 1'b0;
          st_reg     <= ST_RACK;
        end else begin
          tx_reg     <= {tx_reg[6:0], 1'b0};
          sda_oe_reg <= ~tx_reg[6];
        end
        default: ;
      endcase
    end
  end

  // only offset and configuration are writable; result registers ignore writes
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      cfg_reg  <= CFG_RST;
      offs_reg <= OFFS_RST;
    end else if (wr_en && cmd_reg == CMD_CFG) begin
      cfg_reg <= rx_reg;
    end else if (wr_en && cmd_reg == CMD_OFFS) begin
      offs_reg <= rx_reg;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // conversion sequencer: runs from reset release, never pauses
  smtrp_sq_t     seq_reg;
  logic [CW-1:0] seq_cnt_reg;
  wire logic two_th    = cfg_reg[CFG_TWO_TH];
  wire logic seq_diode = (seq_reg == SQ_LOW) | (seq_reg == SQ_HIGH);
  wire logic [CW-1:0] phase_len = seq_diode ? LEN_HALF : LEN_FULL;
  wire logic phase_end = (seq_cnt_reg == phase_len - CW'(1));
  // die channel: low bias then high bias; then channel two, whatever its use
  wire smtrp_sq_t seq_after =
      (seq_reg == SQ_LOW) ? SQ_HIGH :
      (seq_reg == SQ_TH2) ? (two_th ? SQ_TH1 : SQ_LOW) :
      SQ_TH2;
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      seq_reg     <= SQ_LOW;
      seq_cnt_reg <= '0;
    end else if (phase_end) begin
      seq_reg     <= seq_after;
      seq_cnt_reg <= '0;
    end else begin
      seq_cnt_reg <= seq_cnt_reg + CW'(1);
    end
  end

  // result: eighths of a degree or, for thermistors, fraction-of-reference code
  // offset applies to thermistor channels in whole lsb steps
  wire logic seq_th = (seq_reg == SQ_TH1) | (seq_reg == SQ_TH2);
  wire logic signed [13:0] adc_x  = 14'(adc_result_i);
  wire logic signed [13:0] offs_x = seq_th ? 14'(signed'({offs_reg, 3'h0})) : 14'h0000;
  wire logic signed [13:0] sum    = 14'(adc_x + offs_x);
  wire logic sum_neg = sum[13];
  wire logic sum_big = ~sum_neg & (sum[12:11] != 2'h0);
  wire logic [7:0] temp_new =
      sum_neg ? TEMP_RST :
      sum_big ? TEMP_MAX : sum[10:3];
  wire logic [FRAC_BITS-1:0] frac_new = (sum_neg | sum_big) ? '0 : sum[2:0];

  // whole byte loads in one edge; a read copies it into tx_reg at once
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      ch1_reg  <= TEMP_RST;
      ch2_reg  <= TEMP_RST;
      frac_reg <= '0;
    end else if (phase_end) begin
      if (seq_reg == SQ_HIGH) begin
        ch1_reg  <= temp_new;
        frac_reg <= frac_new;
      end
      if (seq_reg == SQ_TH1) ch1_reg <= temp_new;
      if (seq_reg == SQ_TH2) ch2_reg <= temp_new;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // outputs; sda is open drain so only the enable ever moves
  assign sda_o       = 1'b0;
  assign sda_oe_o    = sda_oe_reg;
  assign adc_chan_o  = seq_reg[3];
  assign bias_high_o = seq_reg[1];
  assign two_th_o    = cfg_reg[CFG_TWO_TH];

  ////////////////////////////////////////////////////////////////////////////
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rstn_i);

  ack_addr_a:
  assert property ((st_reg == ST_ADDR && scl_fall && full_reg && addr_hit && !bus_stop)
                   |=> st_reg == ST_ACK_A && sda_oe_o)
    else $error("own address not acknowledged");

  msb_first_a:
  assert property (st_reg == ST_RDATA |-> sda_oe_o == !tx_reg[7])
    else $error("data line does not follow shifter msb");

  cmd_keep_a:
  assert property ((st_reg == ST_CMD && scl_fall && full_reg && !bus_start && !bus_stop)
                   |=> cmd_reg == $past(rx_reg) && st_reg == ST_ACK_C)
    else $error("command byte not retained");

  recv_data_a:
  assert property ((st_reg == ST_ACK_A && scl_fall && rw_reg && !ara_reg)
                   |=> tx_reg == $past(rd_data))
    else $error("read returns wrong register");

  ara_addr_a:
  assert property ((st_reg == ST_ACK_A && scl_fall && rw_reg && ara_reg)
                   |=> tx_reg == {own_addr_reg, 1'b0})
    else $error("alert response address wrong");

  clamp_zero_a:
  assert property ((phase_end && sum_neg && seq_reg == SQ_TH2) |=> ch2_reg == 8'h00)
    else $error("negative result not clipped");

  both_chan_a:
  assert property ((phase_end && (seq_reg == SQ_HIGH || seq_reg == SQ_TH1))
                   |=> seq_reg == SQ_TH2 ##1 seq_cnt_reg == CW'(1))
    else $error("second channel skipped");

  bias_order_a:
  assert property ((seq_reg == SQ_HIGH && $past(seq_reg) != SQ_HIGH)
                   |-> $past(seq_reg) == SQ_LOW && $past(phase_end))
    else $error("high bias without low bias first");

  phase_len_a:
  assert property (seq_cnt_reg < phase_len)
    else $error("integration phase overrun");
endmodule
`default_nettype wire

/* File: sim/smtrp_host.sv */
// smbus host model: makes the serial clock and pulls data low, open drain
`timescale 1ns/1ps
`default_nettype none
module smtrp_host (
  input  wire logic clk_i,
  input  wire logic sda_i,
  output logic      scl_o,
  output logic      sda_low_o
);
  // clock stands high outside frames, data released to the pull-up
  initial begin
    scl_o     = 1'b1;
    sda_low_o = 1'b0;
  end
  task automatic w(input int n);
    repeat (n) @(negedge clk_i);
  endtask
  // start and repeated start; sole master, so the selected register stays ours
  task automatic start();
    w(2);
    sda_low_o = 1'b0;
    w(2);
    scl_o = 1'b1;
    w(4);
    sda_low_o = 1'b1;
    w(4);
    scl_o = 1'b0;
  endtask
  task automatic stop();
    w(2);
    sda_low_o = 1'b1;
    w(2);
    scl_o = 1'b1;
    w(4);
    sda_low_o = 1'b0;
    w(4);
  endtask
  // data changes mid-low; the line is read at the end of the high phase,
  // well after the slave's 3-4 clock turnaround
  task automatic bit_io(input logic b, output logic r);
    w(2);
    sda_low_o = ~b;
    w(2);
    scl_o = 1'b1;
    w(3);
    r = sda_i;
    w(1);
    scl_o = 1'b0;
  endtask
  // eight bits most significant first, then the ninth bit driven as last_b
  task automatic xfer(input logic [7:0] d, input logic last_b,
                      output logic [7:0] q, output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--) begin
      bit_io(d[i], q[i]);
    end
    bit_io(last_b, r);
    ack = ~r;
  endtask
endmodule
`default_nettype wire

/* File: sim/tb_smtrp_top.sv */
// testbench: temperature register port reached through the host model
`timescale 1ns/1ps
`default_nettype none
module tb_smtrp_top;
  import smtrp_pkg::*;
  localparam int unsigned CYC = 40;
  localparam logic signed [11:0] VT [5] = '{12'sh0c8, 12'sh0cb, 12'shfff, 12'sh7ff, 12'sh028};
  localparam logic [7:0] OT [5] = '{8'h00, 8'h00, 8'h00, 8'h10, 8'hf0};
  logic              clk_i = 1'b0;
  logic              rstn_i = 1'b0;
  logic [1:0]        st_a = 2'h0;
  logic [1:0]        st_b = 2'h0;
  logic              alert = 1'b0;
  logic signed [ADC_W-1:0] adc = '0;
  logic              scl, sda_low, sda_o, sda_oe, chan, bias, two_th;
  wire               sda_w = ~(sda_low | (sda_oe & ~sda_o));
  int                miscompares = 0;
  int                checks = 0;
  int                seed = 15;
  smtrp_top #(.CONV_CYC_P(CYC)) dut (
    .clk_i(clk_i), .rstn_i(rstn_i), .scl_i(scl), .sda_i(sda_w), .sda_o(sda_o),
    .sda_oe_o(sda_oe), .slave_addr_strap_a_i(st_a), .slave_addr_strap_b_i(st_b),
    .alert_pend_i(alert), .adc_result_i(adc), .adc_chan_o(chan), .bias_high_o(bias),
    .two_th_o(two_th));
  smtrp_host host (.clk_i(clk_i), .sda_i(sda_w), .scl_o(scl), .sda_low_o(sda_low));
  always #5 clk_i = ~clk_i;
  ////////////////////////////////////////////////////////////////////////////
  task automatic test_done();
    if (miscompares == 0 && checks > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    checks++;
    if (seen !== exp) begin
      miscompares++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  // thermistor phases add the offset in whole degrees, i.e. eighths times 8
  function automatic logic [7:0] exp_t(input logic signed [ADC_W-1:0] v,
                                       input logic [7:0] off, input bit th);
    int s;
    s = (int'(v) + (th ? 8 * int'($signed(off)) : 0)) >>> 3;
    return (s < 0) ? 8'h00 : (s > 255) ? 8'hff : 8'(s);
  endfunction
  function automatic logic [7:0] exp_f(input logic signed [ADC_W-1:0] v);
    int s;
    s = int'(v) >>> 3;
    return (s < 0 || s > 255) ? 8'h00 : {v[2:0], 5'h00};
  endfunction
  task automatic rd(input logic [6:0] a, input logic [7:0] c,
                    output logic [7:0] d, output logic ok);
    logic [7:0] q;
    logic k1, k2, k3, k4;
    host.start();
    host.xfer({a, 1'b0}, 1'b1, q, k1);
    host.xfer(c, 1'b1, q, k2);
    host.start();
    host.xfer({a, 1'b1}, 1'b1, q, k3);
    host.xfer(8'hff, 1'b1, d, k4);
    host.stop();
    ok = k1 & k2 & k3;
  endtask
  // with_d low makes this a send byte
  task automatic wr(input logic [6:0] a, input logic [7:0] c, input logic [7:0] d,
                    input bit with_d);
    logic [7:0] q;
    logic k;
    host.start();
    host.xfer({a, 1'b0}, 1'b1, q, k);
    host.xfer(c, 1'b1, q, k);
    if (with_d) host.xfer(d, 1'b1, q, k);
    host.stop();
  endtask
  task automatic rcv(input logic [6:0] a, output logic [7:0] d, output logic ok);
    logic k;
    host.start();
    host.xfer({a, 1'b1}, 1'b1, d, ok);
    host.xfer(8'hff, 1'b1, d, k);
    host.stop();
  endtask
  task automatic rst(input logic [1:0] a, input logic [1:0] b);
    @(negedge clk_i);
    rstn_i = 1'b0;
    st_a = a;
    st_b = b;
    repeat (16) @(negedge clk_i);
    chk(8'({sda_oe, chan, bias, two_th}), 8'h00);
    rstn_i = 1'b1;
    repeat (10) @(negedge clk_i);
  endtask
  // cycles a phase output stays high; bounded so a stuck sequencer ends the run
  task automatic cnt_hi(input bit sel, output int n);
    int t;
    int u;
    n = 0;
    for (u = 0; u < 500 && (sel ? chan : bias) !== 1'b1; u++) @(negedge clk_i);
    for (t = 0; t < 500 && (sel ? chan : bias) === 1'b1; t++) begin
      @(negedge clk_i);
      n++;
    end
    // a phase that never starts or never ends both count as a hang
    if (t >= 500 || u >= 500) begin
      miscompares++;
      test_done();
    end
  endtask
  ////////////////////////////////////////////////////////////////////////////
  initial begin
    logic [7:0] d, off;
    logic ok;
    int n;
    logic [6:0] sa;
    logic signed [ADC_W-1:0] v;
    for (int i = 0; i < 9; i++) begin
      rst(2'(i / 3), 2'(i % 3));
      rd(ADDR_TBL[i], CMD_CFG, d, ok);
      chk(8'(ok), 8'h01);
      chk(d, CFG_RST);
      rd(ADDR_TBL[(i + 1) % 9], CMD_CFG, d, ok);
      chk(8'(ok), 8'h00);
    end
    // strap code 3 must behave as a high level
    sa = ADDR_TBL[8];
    rst(2'h3, 2'h3);
    cnt_hi(1'b0, n);
    chk(8'(n), 8'(CYC / 2));
    cnt_hi(1'b1, n);
    chk(8'(n), 8'(CYC));
    rd(sa, 8'h7e, d, ok);
    chk(8'(ok), 8'h01);
    chk(d, 8'h00);
    // corners first, then random readings and offsets
    for (int i = 0; i < 8; i++) begin
      v = (i < 5) ? VT[i] : ADC_W'($random(seed));
      off = (i < 5) ? OT[i] : 8'($random(seed));
      wr(sa, CMD_OFFS, off, 1'b1);
      adc = v;
      repeat (200) @(negedge clk_i);
      wr(sa, CMD_CH1, 8'h5a, 1'b1);
      rd(sa, CMD_CH1, d, ok);
      chk(d, exp_t(v, off, 1'b0));
      rd(sa, CMD_CH2, d, ok);
      chk(d, exp_t(v, off, 1'b1));
      rd(sa, CMD_FRAC, d, ok);
      chk(d, exp_f(v));
      wr(sa, CMD_CH2, 8'h00, 1'b0);
      rcv(sa, d, ok);
      chk(d, exp_t(v, off, 1'b1));
    end
    // fixed reading and offset so that die and thermistor results differ
    off = OT[3];
    v = VT[0];
    wr(sa, CMD_OFFS, off, 1'b1);
    adc = v;
    wr(sa, CMD_CFG, 8'h01, 1'b1);
    repeat (200) @(negedge clk_i);
    chk(8'(two_th), 8'h01);
    rd(sa, CMD_CFG, d, ok);
    chk(d, 8'h01);
    rd(sa, CMD_OFFS, d, ok);
    chk(d, off);
    rd(sa, CMD_CH1, d, ok);
    chk(d, exp_t(v, off, 1'b1));
    alert = 1'b1;
    rcv(ARA_ADDR, d, ok);
    chk(d, {sa, 1'b0});
    alert = 1'b0;
    rcv(ARA_ADDR, d, ok);
    chk(8'(ok), 8'h00);
    test_done();
  end
endmodule
`default_nettype wire
